// *** src/bce_pkg.sv ***
package bce_pkg;
  // register map, byte addresses on the 32-bit slave port
  localparam int unsigned AVS_AW    = 5;
  localparam logic [4:0]  OFS_CTRL  = 5'h00;
  localparam logic [4:0]  OFS_STAT  = 5'h04;
  localparam logic [4:0]  OFS_STATE = 5'h08;
  localparam logic [4:0]  OFS_KEY   = 5'h0C;
  localparam logic [4:0]  OFS_ISTAT = 5'h10;
  localparam logic [4:0]  OFS_IMASK = 5'h14;

  // control register bits
  localparam int unsigned CTRL_GO   = 0;
  localparam int unsigned CTRL_DEC  = 1;
  localparam int unsigned CTRL_AUTO = 2;
  localparam int unsigned CTRL_XOR  = 3;
  localparam int unsigned CTRL_CLR  = 4;

  // status register bits
  localparam int unsigned STAT_BUSY  = 0;
  localparam int unsigned STAT_FULL  = 1;
  localparam int unsigned STAT_KFULL = 2;

  // interrupt status and mask layout
  localparam int unsigned IRQ_W    = 1;
  localparam int unsigned IRQ_DONE = 0;

  // block geometry and timing
  localparam int unsigned BLK_BYTES        = 16;
  localparam int unsigned CYCLES_PER_BLOCK = 375;
  localparam logic [3:0]  LAST_IDX         = 4'hF;
  localparam logic [3:0]  ROUNDS           = 4'hA;
  localparam logic [3:0]  FIRST_RND        = 4'h1;

  // cipher arithmetic constants
  localparam logic [7:0]  GF_POLY  = 8'h1B;
  localparam logic [7:0]  SBOX_C   = 8'h63;
  localparam logic [7:0]  ISBOX_C  = 8'h05;
  localparam logic [7:0]  GF_ONE   = 8'h01;
  localparam logic [31:0] MIX_ENC  = 32'h02030101;
  localparam logic [31:0] MIX_DEC  = 32'h0E0B0D09;

  typedef struct packed {
    logic xor_ld;
    logic auto_go;
    logic decrypt;
  } bce_ctrl_t;

  localparam bce_ctrl_t CTRL_RST = '0;
endpackage

// *** src/bce_core.sv ***
module bce_core import bce_pkg::*; (
  input  wire logic         core_clk_i,
  input  wire logic         rst_b_i,
  input  wire logic         go_i,
  input  wire logic         dec_i,
  input  wire logic [127:0] key_i,
  input  wire logic [127:0] blk_i,
  output logic      [127:0] res_o,
  output logic              busy_o
);
  typedef enum logic [1:0] {CORE_IDLE, CORE_KEXP, CORE_RUN} bce_core_st_t;

  function automatic logic [7:0] xt(input logic [7:0] a);
    return {a[6:0], 1'b0} ^ (a[7] ? GF_POLY : 8'h00);
  endfunction

  function automatic logic [7:0] gmul(input logic [7:0] a, input logic [7:0] b);
    logic [7:0] p;
    logic [7:0] x;
    p = 8'h00;
    x = a;
    for (int i = 0; i < 8; i++) begin
      if (b[i]) p = p ^ x;
      x = xt(x);
    end
    return p;
  endfunction

  // inverse as x^254, product of the seven squarings
  function automatic logic [7:0] ginv(input logic [7:0] x);
    logic [7:0] sq;
    logic [7:0] r;
    sq = x;
    r  = GF_ONE;
    for (int i = 1; i < 8; i++) begin
      sq = gmul(sq, sq);
      r  = gmul(r, sq);
    end
    return r;
  endfunction

  function automatic logic [7:0] rl(input logic [7:0] x, input int n);
    return (x << n) | (x >> (8 - n));
  endfunction

  function automatic logic [7:0] sbox(input logic [7:0] x);
    logic [7:0] y;
    y = ginv(x);
    return y ^ rl(y, 1) ^ rl(y, 2) ^ rl(y, 3) ^ rl(y, 4) ^ SBOX_C;
  endfunction

  function automatic logic [7:0] isbox(input logic [7:0] x);
    return ginv(rl(x, 1) ^ rl(x, 3) ^ rl(x, 6) ^ ISBOX_C);
  endfunction

  function automatic logic [31:0] subrot(input logic [31:0] w, input logic [3:0] r);
    logic [7:0] c;
    c = GF_ONE;
    for (int i = 1; i < 10; i++) begin
      if (i < int'(r)) c = xt(c);
    end
    return {sbox(w[23:16]) ^ c, sbox(w[15:8]), sbox(w[7:0]), sbox(w[31:24])};
  endfunction

  function automatic logic [127:0] key_fwd(input logic [127:0] k, input logic [3:0] r);
    logic [31:0] n0;
    logic [31:0] n1;
    logic [31:0] n2;
    n0 = k[127:96] ^ subrot(k[31:0], r);
    n1 = k[95:64] ^ n0;
    n2 = k[63:32] ^ n1;
    return {n0, n1, n2, k[31:0] ^ n2};
  endfunction

  // walks the schedule back from round r to round r-1
  function automatic logic [127:0] key_bwd(input logic [127:0] k, input logic [3:0] r);
    logic [31:0] p3;
    p3 = k[31:0] ^ k[63:32];
    return {k[127:96] ^ subrot(p3, r), k[127:96] ^ k[95:64], k[95:64] ^ k[63:32], p3};
  endfunction

  function automatic logic [31:0] mixcol(input logic [31:0] col, input logic inv);
    logic [31:0] m;
    logic [31:0] o;
    m = inv ? MIX_DEC : MIX_ENC;
    o = '0;
    for (int j = 0; j < 4; j++) begin
      for (int i = 0; i < 4; i++) begin
        o[31-8*j -: 8] = o[31-8*j -: 8] ^ gmul(col[31-8*((j+i)%4) -: 8], m[31-8*i -: 8]);
      end
    end
    return o;
  endfunction

  function automatic logic [127:0] aes_round(input logic [127:0] s, input logic [127:0] k,
                                             input logic dec, input logic last);
    logic [127:0] t;
    int           src;
    t = '0;
    for (int i = 0; i < 16; i++) begin
      src = dec ? (i % 4 + 4 * ((i / 4 + 4 - i % 4) % 4)) : (i % 4 + 4 * ((i / 4 + i % 4) % 4));
      t[127-8*i -: 8] = dec ? isbox(s[127-8*src -: 8]) : sbox(s[127-8*src -: 8]);
    end
    if (dec) t = t ^ k;
    if (!last) begin
      for (int c = 0; c < 4; c++) t[127-32*c -: 32] = mixcol(t[127-32*c -: 32], dec);
    end
    if (!dec) t = t ^ k;
    return t;
  endfunction

  bce_core_st_t ph;
  bce_core_st_t next_ph;
  logic [127:0] st;
  logic [127:0] next_st;
  logic [127:0] rk;
  logic [127:0] next_rk;
  logic [3:0]   rnd;
  logic [3:0]   next_rnd;
  logic         dec;
  logic         next_dec;

  always_comb begin
    logic [127:0] nk;
    nk       = dec ? key_bwd(rk, rnd) : key_fwd(rk, rnd);
    next_ph  = ph;
    next_st  = st;
    next_rk  = rk;
    next_rnd = rnd;
    next_dec = dec;
    case (ph)
      CORE_IDLE: begin
        if (go_i) begin
          next_dec = dec_i;
          next_rnd = FIRST_RND;
          next_rk  = key_i;
          if (dec_i) begin
            next_ph = CORE_KEXP;
          end else begin
            next_st = blk_i ^ key_i;
            next_ph = CORE_RUN;
          end
        end
      end
      CORE_KEXP: begin
        // decryption needs the last round key first
        next_rk = key_fwd(rk, rnd);
        if (rnd == ROUNDS) begin
          next_st = blk_i ^ next_rk;
          next_ph = CORE_RUN;
        end else begin
          next_rnd = rnd + 4'h1;
        end
      end
      CORE_RUN: begin
        next_rk = nk;
        next_st = aes_round(st, nk, dec, dec ? (rnd == FIRST_RND) : (rnd == ROUNDS));
        if (dec ? (rnd == FIRST_RND) : (rnd == ROUNDS)) begin
          next_ph = CORE_IDLE;
        end else begin
          next_rnd = dec ? rnd - 4'h1 : rnd + 4'h1;
        end
      end
      default: next_ph = CORE_IDLE;
    endcase
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ph  <= CORE_IDLE;
      st  <= '0;
      rk  <= '0;
      rnd <= '0;
      dec <= 1'b0;
    end else begin
      ph  <= next_ph;
      st  <= next_st;
      rk  <= next_rk;
      rnd <= next_rnd;
      dec <= next_dec;
    end
  end

  assign res_o  = st;
  assign busy_o = (ph != CORE_IDLE);
endmodule

// *** src/bce_top.sv ***
// How it works
// - Blocks of 128 bits are encrypted or decrypted under a 128-bit key.
// - Each operation ends exactly 375 clock cycles after the start edge.
// - At the end the result sits in state memory and a maskable done interrupt is raised.
// - A one-cycle DMA trigger pulse marks the end of every operation.
// - With auto-start on, writing the sixteenth state byte starts the engine.
// - In xor load mode each written state byte is xored onto the stored byte.
//
// The implementer's own choices: the Avalon-MM register port and the placing of the registers.
module bce_top import bce_pkg::*; #(
  parameter int unsigned OP_CYCLES = CYCLES_PER_BLOCK
) (
  input  wire logic              core_clk_i,
  input  wire logic              rst_b_i,
  input  wire logic [AVS_AW-1:0] avs_address_i,
  input  wire logic              avs_read_i,
  input  wire logic              avs_write_i,
  input  wire logic [31:0]       avs_writedata_i,
  input  wire logic [3:0]        avs_byteenable_i,
  output logic      [31:0]       avs_readdata_o,
  output logic                   avs_waitrequest_o,
  output logic                   irq_o,
  output logic                   dma_trig_o
);
  localparam int unsigned    CNT_W    = $clog2(OP_CYCLES + 1);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(1);
  localparam logic [CNT_W-1:0] CNT_LOAD = CNT_W'(OP_CYCLES);

  bce_ctrl_t        ctrl;
  bce_ctrl_t        next_ctrl;
  logic [7:0]       st_mem [BLK_BYTES];
  logic [7:0]       next_st_mem [BLK_BYTES];
  logic [7:0]       key_mem [BLK_BYTES];
  logic [7:0]       next_key_mem [BLK_BYTES];
  logic [3:0]       st_wp;
  logic [3:0]       next_st_wp;
  logic [3:0]       st_rp;
  logic [3:0]       next_st_rp;
  logic [3:0]       key_wp;
  logic [3:0]       next_key_wp;
  logic             st_full;
  logic             next_st_full;
  logic             key_full;
  logic             next_key_full;
  logic             busy;
  logic             next_busy;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;
  logic             go;
  logic             next_go;
  logic [IRQ_W-1:0] istat;
  logic [IRQ_W-1:0] next_istat;
  logic [IRQ_W-1:0] imask;
  logic [IRQ_W-1:0] next_imask;
  logic             next_irq;
  logic             next_dma;
  logic             wreq;
  logic             next_wreq;
  logic [31:0]      rdata;
  logic [31:0]      next_rdata;
  logic [127:0]     key_blk;
  logic [127:0]     st_blk;
  logic [127:0]     core_res;
  logic             core_busy;
  logic             acc;
  logic             wr_acc;
  logic             rd_acc;
  logic             finish;

  always_comb begin
    for (int i = 0; i < BLK_BYTES; i++) begin
      st_blk[127-8*i -: 8]  = st_mem[i];
      key_blk[127-8*i -: 8] = key_mem[i];
    end
  end

  bce_core u_core (
    .core_clk_i (core_clk_i),
    .rst_b_i    (rst_b_i),
    .go_i       (go),
    .dec_i      (ctrl.decrypt),
    .key_i      (key_blk),
    .blk_i      (st_blk),
    .res_o      (core_res),
    .busy_o     (core_busy)
  );

  // request is taken on the edge where waitrequest is already low
  assign acc    = (avs_read_i || avs_write_i) && !wreq;
  assign wr_acc = acc && avs_write_i && avs_byteenable_i[0];
  assign rd_acc = acc && avs_read_i;
  assign finish = busy && (cnt == CNT_LAST);

  always_comb begin
    logic       start;
    logic [7:0] wb;
    start         = 1'b0;
    wb            = avs_writedata_i[7:0];
    next_ctrl     = ctrl;
    next_st_mem   = st_mem;
    next_key_mem  = key_mem;
    next_st_wp    = st_wp;
    next_st_rp    = st_rp;
    next_key_wp   = key_wp;
    next_st_full  = st_full;
    next_key_full = key_full;
    next_busy     = busy;
    next_cnt      = cnt;
    next_istat    = istat;
    next_imask    = imask;
    next_rdata    = rdata;
    next_wreq     = !((avs_read_i || avs_write_i) && wreq);

    if ((avs_read_i || avs_write_i) && wreq) begin
      case (avs_address_i)
        OFS_CTRL:  next_rdata = {27'h0, 1'b0, ctrl.xor_ld, ctrl.auto_go, ctrl.decrypt, 1'b0};
        OFS_STAT:  next_rdata = {29'h0, key_full, st_full, busy};
        OFS_STATE: next_rdata = {24'h0, st_mem[st_rp]};
        OFS_ISTAT: next_rdata = {{(32-IRQ_W){1'b0}}, istat};
        OFS_IMASK: next_rdata = {{(32-IRQ_W){1'b0}}, imask};
        default:   next_rdata = 32'h0;
      endcase
    end

    if (rd_acc && avs_address_i == OFS_STATE) next_st_rp = st_rp + 4'h1;

    if (wr_acc) begin
      case (avs_address_i)
        OFS_CTRL: begin
          next_ctrl.decrypt = wb[CTRL_DEC];
          next_ctrl.auto_go = wb[CTRL_AUTO];
          next_ctrl.xor_ld  = wb[CTRL_XOR];
          start             = wb[CTRL_GO];
          if (wb[CTRL_CLR] && !busy) begin
            next_st_wp    = '0;
            next_st_rp    = '0;
            next_key_wp   = '0;
            next_st_full  = 1'b0;
            next_key_full = 1'b0;
          end
        end
        OFS_STATE: begin
          // memories are frozen while the core reads them
          if (!busy) begin
            next_st_mem[st_wp] = ctrl.xor_ld ? (st_mem[st_wp] ^ wb) : wb;
            next_st_wp         = st_wp + 4'h1;
            if (st_wp == LAST_IDX) begin
              next_st_full = 1'b1;
              start        = ctrl.auto_go;
            end
          end
        end
        OFS_KEY: begin
          if (!busy) begin
            next_key_mem[key_wp] = wb;
            next_key_wp          = key_wp + 4'h1;
            if (key_wp == LAST_IDX) next_key_full = 1'b1;
          end
        end
        OFS_ISTAT: next_istat = istat & ~avs_writedata_i[IRQ_W-1:0];
        OFS_IMASK: next_imask = avs_writedata_i[IRQ_W-1:0];
        default: ;
      endcase
    end

    if (busy) next_cnt = cnt - CNT_LAST;

    // set after the clear so a done in the clearing cycle survives
    if (finish) begin
      next_busy            = 1'b0;
      next_istat[IRQ_DONE] = 1'b1;
      next_st_wp           = '0;
      next_st_rp           = '0;
      next_st_full         = 1'b0;
      for (int i = 0; i < BLK_BYTES; i++) next_st_mem[i] = core_res[127-8*i -: 8];
    end

    next_go = start && !busy;
    if (next_go) begin
      next_busy = 1'b1;
      next_cnt  = CNT_LOAD;
    end

    next_dma = finish;
    next_irq = |(next_istat & next_imask);
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ctrl              <= CTRL_RST;
      st_mem            <= '{default: '0};
      key_mem           <= '{default: '0};
      st_wp             <= '0;
      st_rp             <= '0;
      key_wp            <= '0;
      st_full           <= 1'b0;
      key_full          <= 1'b0;
      busy              <= 1'b0;
      cnt               <= '0;
      go                <= 1'b0;
      istat             <= '0;
      imask             <= '0;
      irq_o             <= 1'b0;
      dma_trig_o        <= 1'b0;
      wreq              <= 1'b1;
      rdata             <= '0;
    end else begin
      ctrl              <= next_ctrl;
      st_mem            <= next_st_mem;
      key_mem           <= next_key_mem;
      st_wp             <= next_st_wp;
      st_rp             <= next_st_rp;
      key_wp            <= next_key_wp;
      st_full           <= next_st_full;
      key_full          <= next_key_full;
      busy              <= next_busy;
      cnt               <= next_cnt;
      go                <= next_go;
      istat             <= next_istat;
      imask             <= next_imask;
      irq_o             <= next_irq;
      dma_trig_o        <= next_dma;
      wreq              <= next_wreq;
      rdata             <= next_rdata;
    end
  end

  assign avs_waitrequest_o = wreq;
  assign avs_readdata_o    = rdata;

  // helper state watched only by the checks below
  logic [CNT_W-1:0] el;
  logic             xor_v;
  logic [3:0]       xor_idx;
  logic [7:0]       xor_exp;

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      el      <= '0;
      xor_v   <= 1'b0;
      xor_idx <= '0;
      xor_exp <= '0;
    end else begin
      el      <= busy ? el + CNT_LAST : '0;
      xor_v   <= wr_acc && avs_address_i == OFS_STATE && !busy && ctrl.xor_ld;
      xor_idx <= st_wp;
      xor_exp <= st_mem[st_wp] ^ avs_writedata_i[7:0];
    end
  end

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);

  sequence s_last_byte;
    wr_acc && avs_address_i == OFS_STATE && !busy && st_wp == LAST_IDX && ctrl.auto_go;
  endsequence

  sequence s_done_edge;
    $fell(busy);
  endsequence

  sequence s_stat_read;
    avs_read_i && wreq && avs_address_i == OFS_STAT;
  endsequence

  op_length_a: assert property (s_done_edge |-> el == CNT_LOAD)
    else $error("operation length differs from the block time");
  core_ahead_a: assert property (s_done_edge |-> !core_busy)
    else $error("core still running when the block time ends");
  result_load_a: assert property (s_done_edge |-> st_blk == $past(core_res))
    else $error("state memory does not hold the core result");
  done_flag_a: assert property (s_done_edge |-> istat[IRQ_DONE] ##1 irq_o == imask[IRQ_DONE])
    else $error("done flag or interrupt missing after completion");
  dma_pulse_a: assert property (s_done_edge |-> dma_trig_o ##1 !dma_trig_o)
    else $error("dma trigger is not a single pulse at completion");
  auto_start_a: assert property (s_last_byte |=> busy && go ##1 !go)
    else $error("auto start did not follow the last state byte");
  xor_load_a: assert property (xor_v |-> st_mem[xor_idx] == xor_exp)
    else $error("xor load stored the wrong byte");
  busy_status_a: assert property (s_stat_read |=> avs_readdata_o[STAT_BUSY] == $past(busy))
    else $error("status busy bit does not follow the engine");
  wait_answer_a: assert property ((avs_read_i || avs_write_i) && wreq |=> !wreq)
    else $error("waitrequest not released one cycle after a request");
endmodule

// *** dv/bce_host.sv ***
module bce_host import bce_pkg::*; (
  input  wire logic              core_clk_i,
  output logic      [AVS_AW-1:0] avs_address_o,
  output logic                   avs_read_o,
  output logic                   avs_write_o,
  output logic      [31:0]       avs_writedata_o,
  output logic      [3:0]        avs_byteenable_o,
  input  wire logic [31:0]       avs_readdata_i,
  input  wire logic              avs_waitrequest_i
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    avs_address_o    = '0;
    avs_read_o       = 1'b0;
    avs_write_o      = 1'b0;
    avs_writedata_o  = '0;
    avs_byteenable_o = 4'hF;
  end

  // request held until waitrequest is sampled low; data taken at that edge
  task automatic xfer(input logic is_wr, input logic [AVS_AW-1:0] a, input logic [31:0] d,
                      input logic [3:0] be, output logic [31:0] q);
    @(posedge core_clk_i);
    avs_address_o    <= a;
    avs_writedata_o  <= d;
    avs_byteenable_o <= be;
    avs_write_o      <= is_wr;
    avs_read_o       <= !is_wr;
    do @(posedge core_clk_i); while (avs_waitrequest_i !== 1'b0);
    q = avs_readdata_i;
    avs_write_o     <= 1'b0;
    avs_read_o      <= 1'b0;
    // idle bus must not look like the last request
    avs_address_o   <= ~a;
    avs_writedata_o <= ~d;
  endtask

  task automatic wr(input logic [AVS_AW-1:0] a, input logic [31:0] d,
                    input logic [3:0] be = 4'hF);
    logic [31:0] q;
    xfer(1'b1, a, d, be, q);
  endtask

  task automatic rd(input logic [AVS_AW-1:0] a, output logic [31:0] q);
    xfer(1'b0, a, 32'h0, 4'hF, q);
  endtask

  // first byte on the bus is the top byte of the block
  task automatic put16(input logic [AVS_AW-1:0] a, input logic [127:0] v);
    for (int i = 0; i < 16; i++) begin
      wr(a, {24'h0, v[127-8*i -: 8]});
    end
  endtask

  task automatic get16(output logic [127:0] v);
    logic [31:0] q;
    for (int i = 0; i < 16; i++) begin
      rd(OFS_STATE, q);
      v[127-8*i -: 8] = q[7:0];
    end
  endtask

  task automatic load(input logic [127:0] k, input logic [127:0] v); // full key then block
    put16(OFS_KEY, k);
    put16(OFS_STATE, v);
  endtask
endmodule

// *** dv/tb.sv ***
`define CHK(nm, exp, got) begin comparisons++; if ((got) !== (exp)) begin error_cnt++; \
  $display("mismatch %s expected %0h seen %0h", nm, exp, got); end end

module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import bce_pkg::*;

  // short op length keeps the run brief; the core needs at least 22
  localparam int unsigned OPC = 32;
  localparam logic [127:0] K1 = 128'h000102030405060708090A0B0C0D0E0F;
  localparam logic [127:0] P1 = 128'h00112233445566778899AABBCCDDEEFF;
  localparam logic [127:0] C1 = 128'h69C4E0D86A7B0430D8CDB78070B4C55A;
  localparam logic [127:0] K2 = 128'h2B7E151628AED2A6ABF7158809CF4F3C;
  localparam logic [127:0] P2 = 128'h3243F6A8885A308D313198A2E0370734;
  localparam logic [127:0] C2 = 128'h3925841D02DC09FBDC118597196A0B32;
  localparam logic [127:0] XM = 128'hA55A0FF0C33C9669A55A0FF0C33C9669;

  typedef struct packed {
    logic         dec;
    logic         msk;
    logic [127:0] key;
    logic [127:0] din;
    logic [127:0] dout;
  } bce_row_t;

  logic              core_clk;
  logic              rst_b;
  logic [AVS_AW-1:0] addr;
  logic              rd_s;
  logic              wr_s;
  logic [31:0]       wdata;
  logic [3:0]        be;
  logic [31:0]       rdata;
  logic              wait_s;
  logic              irq;
  logic              dma;
  int                error_cnt;
  int                comparisons;
  int                n;
  logic [31:0]       q;
  logic [127:0]      v;
  bce_row_t          rows [4];

  initial core_clk = 1'b0;
  always #4 core_clk = ~core_clk;

  bce_top #(.OP_CYCLES(OPC)) dut_u (
    .core_clk_i        (core_clk),
    .rst_b_i           (rst_b),
    .avs_address_i     (addr),
    .avs_read_i        (rd_s),
    .avs_write_i       (wr_s),
    .avs_writedata_i   (wdata),
    .avs_byteenable_i  (be),
    .avs_readdata_o    (rdata),
    .avs_waitrequest_o (wait_s),
    .irq_o             (irq),
    .dma_trig_o        (dma)
  );

  bce_host host_u (
    .core_clk_i        (core_clk),
    .avs_address_o     (addr),
    .avs_read_o        (rd_s),
    .avs_write_o       (wr_s),
    .avs_writedata_o   (wdata),
    .avs_byteenable_o  (be),
    .avs_readdata_i    (rdata),
    .avs_waitrequest_i (wait_s)
  );

  task automatic results();
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // counts edges from the accepting edge of the start to the trigger pulse
  task automatic wait_done(output int cnt);
    cnt = 0;
    do begin
      @(posedge core_clk);
      #1;
      cnt++;
    end while (dma !== 1'b1 && cnt < 2000);
  endtask

  task automatic clear_done();
    host_u.wr(OFS_ISTAT, 32'h1);
    host_u.rd(OFS_ISTAT, q);
    `CHK("done_clear", 32'h0, q)
    `CHK("irq_clear", 1'b0, irq)
  endtask

  initial begin
    repeat (20000) @(posedge core_clk);
    error_cnt++;
    results();
  end

  initial begin
    rst_b = 1'b0;
    error_cnt = 0;
    comparisons = 0;
    rows[0] = '{1'b0, 1'b1, K1, P1, C1};
    rows[1] = '{1'b1, 1'b0, K1, C1, P1};
    rows[2] = '{1'b0, 1'b0, K2, P2, C2};
    rows[3] = '{1'b1, 1'b1, K2, C2, P2};
    repeat (9) @(posedge core_clk);
    #1;
    `CHK("wait_in_reset", 1'b1, wait_s)
    `CHK("irq_in_reset", 1'b0, irq)
    `CHK("dma_in_reset", 1'b0, dma)
    @(posedge core_clk);
    rst_b <= 1'b1;
    for (int a = 0; a < 32; a += 4) begin
      host_u.rd(a[AVS_AW-1:0], q);
      `CHK("reset_value", 32'h0, q)
    end
    host_u.wr(OFS_IMASK, 32'h1, 4'hE);
    host_u.rd(OFS_IMASK, q);
    `CHK("byteenable_off", 32'h0, q)
    $display("test reset done");

    for (int i = 0; i < 4; i++) begin
      host_u.load(rows[i].key, rows[i].din);
      host_u.wr(OFS_IMASK, {31'h0, rows[i].msk});
      host_u.wr(OFS_CTRL, {30'h0, rows[i].dec, 1'b1});
      wait_done(n);
      `CHK("op_cycles", OPC, n)
      `CHK("irq_at_done", rows[i].msk, irq)
      @(posedge core_clk);
      #1;
      `CHK("dma_one_cycle", 1'b0, dma)
      host_u.rd(OFS_STAT, q);
      `CHK("busy_after", 1'b0, q[STAT_BUSY])
      host_u.rd(OFS_ISTAT, q);
      `CHK("done_flag", 32'h1, q)
      host_u.get16(v);
      `CHK("result", rows[i].dout, v)
      clear_done();
      $display("test row %0d done", i);
    end

    host_u.wr(OFS_CTRL, 32'h4);
    host_u.load(K1, P1);
    wait_done(n);
    `CHK("auto_cycles", OPC, n)
    host_u.get16(v);
    `CHK("auto_result", C1, v)
    clear_done();
    $display("test auto start done");

    host_u.wr(OFS_CTRL, 32'h0);
    host_u.load(K1, C1 ^ XM);
    host_u.rd(OFS_STAT, q);
    `CHK("full_flags", 32'h6, q)
    host_u.wr(OFS_CTRL, 32'h8);
    host_u.put16(OFS_STATE, XM);
    host_u.wr(OFS_CTRL, 32'hB);
    host_u.rd(OFS_STAT, q);
    `CHK("busy_during", 1'b1, q[STAT_BUSY])
    // decryption reads the block late, so a write while busy would show
    host_u.wr(OFS_STATE, 32'hFF);
    wait_done(n);
    host_u.get16(v);
    `CHK("xor_result", P1, v)
    clear_done();
    $display("test xor load done");

    // clear rewinds both pointers, so stray bytes do not shift the next block
    host_u.wr(OFS_STATE, 32'h5A);
    host_u.wr(OFS_KEY, 32'h5A);
    host_u.wr(OFS_CTRL, 32'h10);
    host_u.rd(OFS_STAT, q);
    `CHK("clear_flags", 32'h0, q)
    host_u.load(K2, P2);
    host_u.wr(OFS_CTRL, 32'h1);
    wait_done(n);
    host_u.get16(v);
    `CHK("clear_result", C2, v)
    clear_done();
    $display("test clear done");

    // reset in mid-operation: no completion may follow, engine must recover
    host_u.load(K2, P2);
    host_u.wr(OFS_CTRL, 32'h1);
    repeat (4) @(posedge core_clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst_b <= 1'b1;
    repeat (OPC) @(posedge core_clk);
    host_u.rd(OFS_STAT, q);
    `CHK("stat_after_cut", 32'h0, q)
    host_u.rd(OFS_ISTAT, q);
    `CHK("no_done_after_cut", 32'h0, q)
    host_u.load(K2, P2);
    host_u.wr(OFS_CTRL, 32'h1);
    wait_done(n);
    `CHK("cycles_after_cut", OPC, n)
    host_u.get16(v);
    `CHK("result_after_cut", C2, v)
    $display("test reset mid-run done");
    results();
  end
endmodule
